// file: logic/xad_regs.vh
// Purpose: constants for the access decoder and steering block
// Assumes: 24-bit byte address, 40 MHz CPU clock, APB register port
// Notes: register offsets are byte addresses on the APB
`ifndef XAD_REGS_VH
`define XAD_REGS_VH

// APB register offsets
`define XAD_OFF_SYSCFG 8'h00
`define XAD_OFF_PSEL 8'h04
`define XAD_OFF_STATUS 8'h08
`define XAD_OFF_DEFCFG 8'h0C
`define XAD_OFF_WIN0 8'h10
`define XAD_OFF_CFG0 8'h20

// System config and peripheral select fields
`define XAD_SYSCFG_GEN_BIT 2
`define XAD_PSEL_CAN_CTRL_ONE_BIT 0
`define XAD_PSEL_CAN_CTRL_TWO_BIT 1
`define XAD_PSEL_SRAM_BIT 2
`define XAD_PSEL_LRAM_BIT 3
`define XAD_PSEL_RESET 4'h5
`define XAD_SYSCFG_RESET 16'h0000

// Status fields
`define XAD_ST_BUSY_BIT 0
`define XAD_ST_ERR_BIT 8

// Bus config fields: wait states, width, demux, tri-state wait
`define XAD_CFG_WS_MSB 3
`define XAD_CFG_W16_BIT 4
`define XAD_CFG_DMX_BIT 5
`define XAD_CFG_TRI_BIT 6
`define XAD_CFG_RESET 16'h0030

// Address windows
`define XAD_SRAM_LO 24'h00E000
`define XAD_SRAM_HI 24'h00E7FF
`define XAD_LRAM_LO 24'h00C000
`define XAD_LRAM_HI 24'h00DFFF
`define XAD_CAN_CTRL_ONE_LO 24'h00EF00
`define XAD_CAN_CTRL_ONE_HI 24'h00EFFF
`define XAD_CAN_CTRL_TWO_LO 24'h00EE00
`define XAD_CAN_CTRL_TWO_HI 24'h00EEFF
`define XAD_EXTENDED_SPECIAL_REGS_LO 24'h00F000
`define XAD_EXTENDED_SPECIAL_REGS_HI 24'h00F1FF
`define XAD_INTERNAL_DUAL_PORT_RAM_LO 24'h00F600
`define XAD_INTERNAL_DUAL_PORT_RAM_HI 24'h00FDFF
`define XAD_SFR_LO 24'h00FE00
`define XAD_SFR_HI 24'h00FFFF

// Timing
`define XAD_CLK_MHZ 40
`define XAD_BUS_STATE_NS 50
`define XAD_CAN_ACCESS_NS 100
`define XAD_EXT_BASE_CYC 8'h02
`define XAD_SEG_OE_ALL 8'hFF
`define XAD_SEG_OE_CAN 8'h0F

// Target codes
`define XAD_TGT_EXT 3'h0
`define XAD_TGT_SRAM 3'h1
`define XAD_TGT_LRAM 3'h2
`define XAD_TGT_CAN_CTRL_ONE 3'h3
`define XAD_TGT_CAN_CTRL_TWO 3'h4
`define XAD_TGT_INTERNAL_DUAL_PORT_RAM 3'h5
`define XAD_TGT_SFR 3'h6

`endif

// file: logic/xad_window.v
// Purpose: one external address window with its bus configuration
// Assumes: window holds a 4 KByte page base and a size code
// Notes: size is 4 KByte shifted left by the size code
`timescale 1ns/10ps
`include "xad_regs.vh"

module xad_window (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register writes
    input wire wr_win,
    input wire wr_cfg,
    input wire [15:0] wdata,
    // Match
    input wire [11:0] addr_page,
    output wire hit,
    output reg [15:0] win_q,
    output reg [15:0] cfg_q
);

    wire [11:0] mask;

    // Page mask from the size code
    assign mask = 12'hFFF << win_q[15:12];
    assign hit = (((addr_page ^ win_q[11:0]) & mask) == 12'h000) && (win_q != 16'h0000);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_q <= 16'h0000;
            cfg_q <= `XAD_CFG_RESET;
        end else begin
            if (wr_win) begin
                win_q <= wdata;
            end
            if (wr_cfg) begin
                cfg_q <= wdata;
            end
        end
    end

endmodule // xad_window

// file: logic/xad_decoder.v
// Purpose: decode and steer CPU accesses to on-chip and external targets
// Assumes: CPU request port on clk; registers reached over APB
// Notes: one access outstanding; answer is a one-cycle cpu_ready pulse
//
// How it works
// - Small window goes to small RAM when global and small enables are set.
// - Otherwise small window goes external under the matching window config.
// - Large window goes to large RAM when global and large enables are set.
// - Otherwise large window goes external under the matching window config.
// - Extension RAM: 16-bit demux cycle, no waits, bytes and words.
// - Extension RAM refuses bit, stack and register bank accesses.
// - First CAN window selects first CAN when global and its enable set.
// - Second CAN window selects second CAN when global and its enable set.
// - CAN accesses: demux, 16-bit, two wait states, 100 ns.
// - CAN accesses add no tri-state wait.
// - One linear 16 MByte space, byte or word at any location.
// - Two 512-byte areas reserved for special and extended registers.
// - Stack and register bank accesses go to internal dual-port RAM.
// - External interface reaches up to 16 MBytes.
// - With a CAN in use only 4 segment lines are driven.
// - Reset: first CAN on, second off, small RAM on, large off.
// - Peripheral select is frozen once the global enable is set.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "xad_regs.vh"

module xad_decoder #(
    parameter NWIN = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // CPU access request
    input wire cpu_req,
    input wire [23:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_byte,
    input wire cpu_bit_op,
    input wire cpu_stack_op,
    input wire [15:0] cpu_wdata,
    output reg cpu_ready,
    output reg cpu_err,
    // Target selects
    output reg sel_small_ram,
    output reg sel_large_ram,
    output reg sel_can_one,
    output reg sel_can_two,
    output reg sel_internal_dual_port_ram,
    output reg sel_sfr,
    output reg sel_ext,
    output reg [NWIN-1:0] ext_cs,
    // Access properties
    output reg [23:0] tgt_addr,
    output reg [15:0] tgt_wdata,
    output reg tgt_wr,
    output reg tgt_byte,
    output reg tgt_width16,
    output reg tgt_demux,
    output reg [7:0] ext_seg_oe
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ACC = 3'b010;
    localparam [2:0] ST_TRI = 3'b100;
    localparam integer CYC_STATE_I = `XAD_BUS_STATE_NS * `XAD_CLK_MHZ / 1000;
    localparam integer CYC_CAN_I = `XAD_CAN_ACCESS_NS * `XAD_CLK_MHZ / 1000;
    localparam [7:0] CYC_STATE = CYC_STATE_I[7:0];
    localparam [7:0] CYC_CAN = CYC_CAN_I[7:0];

    reg [15:0] syscfg_q;
    reg [3:0] psel_q;
    reg err_q;
    reg [2:0] last_tgt_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] cnt_q;
    reg [7:0] cnt_d;
    reg tri_q;

    wire gen;
    wire can_one_on;
    wire can_two_on;
    wire small_on;
    wire large_on;
    wire setup;
    wire wr_acc;
    wire [NWIN-1:0] win_hit;
    wire [16*NWIN-1:0] win_all;
    wire [16*NWIN-1:0] cfg_all;
    wire accept;
    wire err_clr;

    // Target enables
    assign gen = syscfg_q[`XAD_SYSCFG_GEN_BIT];
    assign can_one_on = gen && psel_q[`XAD_PSEL_CAN_CTRL_ONE_BIT];
    assign can_two_on = gen && psel_q[`XAD_PSEL_CAN_CTRL_TWO_BIT];
    assign small_on = gen && psel_q[`XAD_PSEL_SRAM_BIT];
    assign large_on = gen && psel_q[`XAD_PSEL_LRAM_BIT];
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pready;
    // No second accept on the edge that delivers the answer
    assign accept = cpu_req && state_q[0] && !cpu_ready;

    // External windows
    genvar gi;
    generate
        for (gi = 0; gi < NWIN; gi = gi + 1) begin : g_win
            xad_window u_win (
                .clk(clk),
                .rst_n(rst_n),
                .wr_win(wr_acc && (paddr == (`XAD_OFF_WIN0 + 8'h04 * gi[7:0]))),
                .wr_cfg(wr_acc && (paddr == (`XAD_OFF_CFG0 + 8'h04 * gi[7:0]))),
                .wdata(pwdata[15:0]),
                .addr_page(cpu_addr[23:12]),
                .hit(win_hit[gi]),
                .win_q(win_all[16*gi+15:16*gi]),
                .cfg_q(cfg_all[16*gi+15:16*gi])
            );
        end
    endgenerate

    reg [15:0] defcfg_q;
    reg [15:0] ext_cfg;
    reg [NWIN-1:0] ext_cs_d;
    reg [2:0] tgt_d;
    reg bad_d;
    integer wi;

    // First matching window wins, else default config
    always @* begin
        ext_cfg = defcfg_q;
        ext_cs_d = {NWIN{1'b0}};
        for (wi = NWIN - 1; wi >= 0; wi = wi - 1) begin
            if (win_hit[wi]) begin
                ext_cfg = cfg_all[16*wi +: 16];
                ext_cs_d = {NWIN{1'b0}};
                ext_cs_d[wi] = 1'b1;
            end
        end
    end

    // Address decode over the 16 MByte space
    always @* begin
        tgt_d = `XAD_TGT_EXT;
        bad_d = 1'b0;
        if (cpu_stack_op) begin
            tgt_d = `XAD_TGT_INTERNAL_DUAL_PORT_RAM;
            bad_d = (cpu_addr < `XAD_INTERNAL_DUAL_PORT_RAM_LO) || (cpu_addr > `XAD_INTERNAL_DUAL_PORT_RAM_HI);
        end else if (cpu_addr >= `XAD_SRAM_LO && cpu_addr <= `XAD_SRAM_HI && small_on) begin
            tgt_d = `XAD_TGT_SRAM;
            bad_d = cpu_bit_op;
        end else if (cpu_addr >= `XAD_LRAM_LO && cpu_addr <= `XAD_LRAM_HI && large_on) begin
            tgt_d = `XAD_TGT_LRAM;
            bad_d = cpu_bit_op;
        end else if (cpu_addr >= `XAD_CAN_CTRL_ONE_LO && cpu_addr <= `XAD_CAN_CTRL_ONE_HI && can_one_on) begin
            tgt_d = `XAD_TGT_CAN_CTRL_ONE;
        end else if (cpu_addr >= `XAD_CAN_CTRL_TWO_LO && cpu_addr <= `XAD_CAN_CTRL_TWO_HI && can_two_on) begin
            tgt_d = `XAD_TGT_CAN_CTRL_TWO;
        end else if ((cpu_addr >= `XAD_SFR_LO && cpu_addr <= `XAD_SFR_HI) ||
                     (cpu_addr >= `XAD_EXTENDED_SPECIAL_REGS_LO && cpu_addr <= `XAD_EXTENDED_SPECIAL_REGS_HI)) begin
            tgt_d = `XAD_TGT_SFR;
        end else if (cpu_addr >= `XAD_INTERNAL_DUAL_PORT_RAM_LO && cpu_addr <= `XAD_INTERNAL_DUAL_PORT_RAM_HI) begin
            tgt_d = `XAD_TGT_INTERNAL_DUAL_PORT_RAM;
        end
        // Disabled RAM and CAN windows fall through to external
    end

    // Access length per target
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_d = ST_ACC;
                    if (bad_d) begin
                        cnt_d = 8'h00;
                    end else if (tgt_d == `XAD_TGT_CAN_CTRL_ONE || tgt_d == `XAD_TGT_CAN_CTRL_TWO) begin
                        cnt_d = CYC_CAN - 8'h01;
                    end else if (tgt_d == `XAD_TGT_EXT) begin
                        cnt_d = `XAD_EXT_BASE_CYC - 8'h01 + {4'h0, ext_cfg[`XAD_CFG_WS_MSB:0]};
                    end else begin
                        cnt_d = CYC_STATE - 8'h01;
                    end
                end
            end
            ST_ACC: begin
                if (cnt_q == 8'h00) begin
                    state_d = tri_q ? ST_TRI : ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ST_TRI: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 8'h00;
            end
        endcase
    end

    // Access sequencer and steering outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            tri_q <= 1'b0;
            cpu_ready <= 1'b0;
            cpu_err <= 1'b0;
            sel_small_ram <= 1'b0;
            sel_large_ram <= 1'b0;
            sel_can_one <= 1'b0;
            sel_can_two <= 1'b0;
            sel_internal_dual_port_ram <= 1'b0;
            sel_sfr <= 1'b0;
            sel_ext <= 1'b0;
            ext_cs <= {NWIN{1'b0}};
            tgt_addr <= 24'h000000;
            tgt_wdata <= 16'h0000;
            tgt_wr <= 1'b0;
            tgt_byte <= 1'b0;
            tgt_width16 <= 1'b0;
            tgt_demux <= 1'b0;
            last_tgt_q <= `XAD_TGT_EXT;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cpu_ready <= 1'b0;
            cpu_err <= 1'b0;
            if (accept) begin
                last_tgt_q <= tgt_d;
                tgt_addr <= cpu_addr;
                tgt_wdata <= cpu_wdata;
                tgt_wr <= cpu_wr;
                tgt_byte <= cpu_byte;
                sel_small_ram <= !bad_d && (tgt_d == `XAD_TGT_SRAM);
                sel_large_ram <= !bad_d && (tgt_d == `XAD_TGT_LRAM);
                sel_can_one <= !bad_d && (tgt_d == `XAD_TGT_CAN_CTRL_ONE);
                sel_can_two <= !bad_d && (tgt_d == `XAD_TGT_CAN_CTRL_TWO);
                sel_internal_dual_port_ram <= !bad_d && (tgt_d == `XAD_TGT_INTERNAL_DUAL_PORT_RAM);
                sel_sfr <= !bad_d && (tgt_d == `XAD_TGT_SFR);
                sel_ext <= !bad_d && (tgt_d == `XAD_TGT_EXT);
                ext_cs <= (!bad_d && tgt_d == `XAD_TGT_EXT) ? ext_cs_d : {NWIN{1'b0}};
                if (tgt_d == `XAD_TGT_EXT) begin
                    tgt_width16 <= ext_cfg[`XAD_CFG_W16_BIT];
                    tgt_demux <= ext_cfg[`XAD_CFG_DMX_BIT];
                    tri_q <= ext_cfg[`XAD_CFG_TRI_BIT] && !bad_d;
                end else begin
                    tgt_width16 <= 1'b1;
                    tgt_demux <= 1'b1;
                    tri_q <= 1'b0;
                end
            end else if (state_q[1] && cnt_q == 8'h00) begin
                cpu_ready <= 1'b1;
                cpu_err <= !(sel_small_ram | sel_large_ram | sel_can_one | sel_can_two |
                             sel_internal_dual_port_ram | sel_sfr | sel_ext);
                sel_small_ram <= 1'b0;
                sel_large_ram <= 1'b0;
                sel_can_one <= 1'b0;
                sel_can_two <= 1'b0;
                sel_internal_dual_port_ram <= 1'b0;
                sel_sfr <= 1'b0;
                sel_ext <= 1'b0;
                ext_cs <= {NWIN{1'b0}};
            end
        end
    end

    // Segment lines limited when a CAN is in use
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_seg_oe <= `XAD_SEG_OE_ALL;
        end else begin
            ext_seg_oe <= (can_one_on || can_two_on) ? `XAD_SEG_OE_CAN : `XAD_SEG_OE_ALL;
        end
    end

    // Configuration registers
    assign err_clr = wr_acc && (paddr == `XAD_OFF_STATUS) && pwdata[`XAD_ST_ERR_BIT];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syscfg_q <= `XAD_SYSCFG_RESET;
            psel_q <= `XAD_PSEL_RESET;
            defcfg_q <= `XAD_CFG_RESET;
            err_q <= 1'b0;
        end else begin
            if (wr_acc && paddr == `XAD_OFF_SYSCFG) begin
                syscfg_q <= pwdata[15:0];
            end
            if (wr_acc && paddr == `XAD_OFF_PSEL && !gen) begin
                psel_q <= pwdata[3:0];
            end
            if (wr_acc && paddr == `XAD_OFF_DEFCFG) begin
                defcfg_q <= pwdata[15:0];
            end
            // Set wins over clear
            if (accept && bad_d) begin
                err_q <= 1'b1;
            end else if (err_clr) begin
                err_q <= 1'b0;
            end
        end
    end

    reg [31:0] rd_d;
    reg hit_d;
    integer ri;

    // Read mux and address check
    always @* begin
        rd_d = 32'h00000000;
        hit_d = 1'b1;
        case (paddr)
            `XAD_OFF_SYSCFG: rd_d = {16'h0000, syscfg_q};
            `XAD_OFF_PSEL: rd_d = {28'h0000000, psel_q};
            `XAD_OFF_STATUS: begin
                rd_d[`XAD_ST_BUSY_BIT] = !state_q[0];
                rd_d[3:1] = last_tgt_q;
                rd_d[`XAD_ST_ERR_BIT] = err_q;
            end
            `XAD_OFF_DEFCFG: rd_d = {16'h0000, defcfg_q};
            default: begin
                hit_d = 1'b0;
                for (ri = 0; ri < NWIN; ri = ri + 1) begin
                    if (paddr == (`XAD_OFF_WIN0 + 8'h04 * ri[7:0])) begin
                        rd_d = {16'h0000, win_all[16*ri +: 16]};
                        hit_d = 1'b1;
                    end
                    if (paddr == (`XAD_OFF_CFG0 + 8'h04 * ri[7:0])) begin
                        rd_d = {16'h0000, cfg_all[16*ri +: 16]};
                        hit_d = 1'b1;
                    end
                end
            end
        endcase
    end

    // APB answer: pready one cycle after setup
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit_d;
            prdata <= (setup && !pwrite) ? rd_d : 32'h00000000;
        end
    end

endmodule // xad_decoder

// file: tb/xad_checker.sv
// Purpose: port checks of the access decoder
// Assumes: one clock, async active-low reset
// Notes: bound into every decoder instance
`timescale 1ns/10ps
module xad_checker #(
    parameter NWIN = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // CPU handshake
    input wire cpu_req,
    input wire cpu_ready,
    input wire cpu_err,
    // Target selects
    input wire sel_small_ram,
    input wire sel_large_ram,
    input wire sel_can_one,
    input wire sel_can_two,
    input wire sel_internal_dual_port_ram,
    input wire sel_sfr,
    input wire sel_ext,
    input wire [NWIN-1:0] ext_cs,
    // Access properties
    input wire [23:0] tgt_addr,
    input wire tgt_width16,
    input wire tgt_demux,
    input wire [7:0] ext_seg_oe
);
    wire ram = sel_small_ram | sel_large_ram;
    wire can = sel_can_one | sel_can_two;
    wire sel_any = ram | can | sel_internal_dual_port_ram | sel_sfr | sel_ext;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_one_target: assert property ($onehot0({sel_small_ram, sel_large_ram, sel_can_one, sel_can_two, sel_internal_dual_port_ram, sel_sfr, sel_ext}))
        else $error("more than one target selected");
    a_small_window: assert property (sel_small_ram |-> tgt_addr >= 24'h00E000 && tgt_addr <= 24'h00E7FF)
        else $error("small ram outside its window");
    a_large_window: assert property (sel_large_ram |-> tgt_addr >= 24'h00C000 && tgt_addr <= 24'h00DFFF)
        else $error("large ram outside its window");
    a_can_one_window: assert property (sel_can_one |-> tgt_addr[23:8] == 16'h00EF)
        else $error("first can outside its window");
    a_can_two_window: assert property (sel_can_two |-> tgt_addr[23:8] == 16'h00EE)
        else $error("second can outside its window");
    a_onchip_format: assert property (ram || can |-> tgt_width16 && tgt_demux)
        else $error("on-chip access not 16-bit demux");
    a_ram_nowait: assert property ($rose(ram) |=> ram ##1 (cpu_ready && !ram))
        else $error("extension ram access not wait-free");
    a_can_waits: assert property ($rose(can) |-> can [*4] ##1 (cpu_ready && !can))
        else $error("can access not two wait states");
    a_can_segment: assert property (can |-> ext_seg_oe == 8'h0F)
        else $error("segment lines not cut with can in use");
    a_err_refused: assert property (cpu_err |-> cpu_ready && !$past(sel_any))
        else $error("refused access had a select");
    a_chipsel_ext: assert property (|ext_cs |-> sel_ext)
        else $error("chip select without external access");
    a_decode_latency: assert property ($rose(cpu_req) |=> (sel_any or ##1 (cpu_ready && cpu_err)))
        else $error("decode added latency");
endmodule // xad_checker

bind xad_decoder xad_checker #(.NWIN(NWIN)) u_chk (
    .clk, .rst_n, .cpu_req, .cpu_ready, .cpu_err, .sel_small_ram, .sel_large_ram,
    .sel_can_one, .sel_can_two, .sel_internal_dual_port_ram, .sel_sfr, .sel_ext, .ext_cs, .tgt_addr,
    .tgt_width16, .tgt_demux, .ext_seg_oe
);

// file: tb/xad_cpu_model.sv
// Purpose: CPU core issuing accesses to the decoder
// Assumes: request held until cpu_ready is sampled high
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module xad_cpu_model (
    // Clock
    input wire clk,
    // Request
    output logic cpu_req,
    output logic [23:0] cpu_addr,
    output logic cpu_wr,
    output logic cpu_byte,
    output logic cpu_bit_op,
    output logic cpu_stack_op,
    output logic [15:0] cpu_wdata,
    // Answer
    input wire cpu_ready
);
    initial begin
        cpu_req = 1'b0;
        cpu_addr = 24'h000000;
        {cpu_wr, cpu_byte, cpu_bit_op, cpu_stack_op} = 4'h0;
        cpu_wdata = 16'h0000;
    end
    // One access; flags are write, byte, bit, stack
    task automatic access(input logic [23:0] a, input logic [3:0] f, input logic [15:0] d);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        {cpu_wr, cpu_byte, cpu_bit_op, cpu_stack_op} <= f;
        cpu_wdata <= d;
        do @(posedge clk); while (cpu_ready !== 1'b1);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
    endtask
endmodule // xad_cpu_model

// file: tb/testbench.sv
// Purpose: self-checking bench of the access decoder
// Assumes: APB master and CPU model move just after rising edges
// Notes: drivers queue expectations, one monitor compares
`timescale 1ns/10ps
`include "xad_regs.vh"
module testbench;
    localparam logic [6:0] S_SR = 7'h40, S_LR = 7'h20, S_C1 = 7'h10, S_C2 = 7'h08;
    localparam logic [6:0] S_IR = 7'h04, S_SF = 7'h02, S_EX = 7'h01;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'h5AE8C553;
    logic [39:0] q_cpu[$], q_apb[$];
    logic [6:0] sv = 7'h0;
    logic [3:0] cv = 4'h0;
    logic [7:0] cnt = 8'h0;
    int n_mismatch = 0, n_tests = 0, cyc = 0, i;
    wire [31:0] prdata;
    wire [23:0] cpu_addr, tgt_addr;
    wire [15:0] cpu_wdata, tgt_wdata;
    wire [7:0] ext_seg_oe;
    wire [3:0] ext_cs;
    wire pready, pslverr, cpu_req, cpu_wr, cpu_byte, cpu_bit_op, cpu_stack_op, cpu_ready, cpu_err;
    wire sel_small_ram, sel_large_ram, sel_can_one, sel_can_two, sel_internal_dual_port_ram, sel_sfr, sel_ext;
    wire tgt_wr, tgt_byte, tgt_width16, tgt_demux;
    wire [6:0] sels = {sel_small_ram, sel_large_ram, sel_can_one, sel_can_two, sel_internal_dual_port_ram, sel_sfr, sel_ext};

    xad_decoder #(.NWIN(4)) u_dut (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cpu_req, .cpu_addr, .cpu_wr, .cpu_byte, .cpu_bit_op, .cpu_stack_op, .cpu_wdata,
        .cpu_ready, .cpu_err, .sel_small_ram, .sel_large_ram, .sel_can_one, .sel_can_two,
        .sel_internal_dual_port_ram, .sel_sfr, .sel_ext, .ext_cs, .tgt_addr, .tgt_wdata, .tgt_wr, .tgt_byte,
        .tgt_width16, .tgt_demux, .ext_seg_oe
    );
    xad_cpu_model u_cpu (
        .clk, .cpu_req, .cpu_addr, .cpu_wr, .cpu_byte, .cpu_bit_op, .cpu_stack_op,
        .cpu_wdata, .cpu_ready
    );

    always #12.5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // APB transfer; on a read d is the expected data
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        q_apb.push_back({7'h0, e, w ? 32'h0 : d});
        seed = lfsr(seed);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : seed;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // CPU access with expected select, select cycles and chip select
    task automatic cpu(input logic [23:0] a, input logic [3:0] f, input logic [6:0] s, input logic [7:0] n,
                       input logic [3:0] cs);
        q_cpu.push_back({20'h0, ~|s, s, cs, n});
        seed = lfsr(seed);
        u_cpu.access(a, f, seed[15:0]);
    endtask

    // Result monitor
    always @(posedge clk) begin
        if (cpu_ready === 1'b1) begin
            chk({20'h0, cpu_err, sv, cv, cnt}, q_cpu.pop_front());
            sv = 7'h0;
            cv = 4'h0;
            cnt = 8'h0;
        end else if (|sels) begin
            sv = sels;
            cv = ext_cs;
            cnt = cnt + 8'h1;
        end
        if (psel && penable && pready === 1'b1)
            chk({7'h0, pslverr, pwrite ? 32'h0 : prdata}, q_apb.pop_front());
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk({32'h0, ext_seg_oe}, 40'hFF);
        apb(0, `XAD_OFF_PSEL, 32'h5, 0);
        apb(0, `XAD_OFF_SYSCFG, 32'h0, 0);
        apb(0, `XAD_OFF_DEFCFG, 32'h30, 0);
        apb(0, `XAD_OFF_CFG0, 32'h30, 0);
        apb(0, 8'h40, 32'h0, 1);
        apb(1, 8'h44, 32'h1, 1);
        cpu(24'h00E000, 4'h0, S_EX, 8'h02, 4'h0);
        cpu(24'h00C000, 4'h8, S_EX, 8'h02, 4'h0);
        cpu(24'h00EF00, 4'h4, S_EX, 8'h02, 4'h0);
        apb(1, `XAD_OFF_DEFCFG, 32'h33, 0);
        apb(1, `XAD_OFF_WIN0, 32'h0100, 0);
        apb(1, `XAD_OFF_CFG0, 32'h31, 0);
        apb(1, `XAD_OFF_PSEL, 32'hF, 0);
        apb(0, `XAD_OFF_PSEL, 32'hF, 0);
        apb(1, `XAD_OFF_SYSCFG, 32'h4, 0);
        apb(1, `XAD_OFF_PSEL, 32'h0, 0);
        apb(0, `XAD_OFF_PSEL, 32'hF, 0);
        chk({32'h0, ext_seg_oe}, 40'h0F);
        cpu(24'h00E000, 4'h8, S_SR, 8'h02, 4'h0);
        cpu(24'h00E7FF, 4'h4, S_SR, 8'h02, 4'h0);
        cpu(24'h00E800, 4'h0, S_EX, 8'h05, 4'h0);
        cpu(24'h00C000, 4'hC, S_LR, 8'h02, 4'h0);
        cpu(24'h00DFFF, 4'h0, S_LR, 8'h02, 4'h0);
        cpu(24'h00BFFF, 4'h0, S_EX, 8'h05, 4'h0);
        cpu(24'h00EF00, 4'h8, S_C1, 8'h04, 4'h0);
        cpu(24'h00EFFF, 4'h4, S_C1, 8'h04, 4'h0);
        cpu(24'h00EE00, 4'h0, S_C2, 8'h04, 4'h0);
        cpu(24'h00EEFF, 4'hC, S_C2, 8'h04, 4'h0);
        cpu(24'h00F700, 4'h1, S_IR, 8'h02, 4'h0);
        cpu(24'h00F100, 4'h4, S_SF, 8'h02, 4'h0);
        cpu(24'h00FE00, 4'h0, S_SF, 8'h02, 4'h0);
        cpu(24'h00E000, 4'h2, 7'h00, 8'h00, 4'h0);
        cpu(24'h00C002, 4'h1, 7'h00, 8'h00, 4'h0);
        cpu(24'h100010, 4'h8, S_EX, 8'h03, 4'h1);
        apb(1, `XAD_OFF_CFG0, 32'h71, 0);
        cpu(24'h100010, 4'h0, S_EX, 8'h03, 4'h1);
        apb(0, `XAD_OFF_STATUS, 32'h100, 0);
        apb(1, `XAD_OFF_STATUS, 32'h100, 0);
        apb(0, `XAD_OFF_STATUS, 32'h0, 0);
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            cpu({4'h2, seed[19:0]}, seed[23:20] & 4'hC, S_EX, 8'h05, 4'h0);
        end
        complete_run();
    end
endmodule // testbench
